// ==== reset_cause_pkg.sv ====
// What this block does
// R1 - Any reset forces only a small register subset; everything else keeps value
// R2 - Watchdog wake-up resumes work and leaves special registers untouched
// R3 - Power-on: restart 0000h, mismatch/instr/timeout/power-down set, rest clear
// R4 - Reset instruction: restart 0000h, clear only the reset-instruction flag
// R5 - Brown-out: restart 0000h, set four flags, clear brown-out flag
// R6 - Mismatch reset: restart 0000h, clear only the mismatch flag
// R7 - Master clear in low-power run: restart 0000h, set timeout flag
// R8 - Master clear in idle or sleep: restart, set timeout, clear power-down
// R9 - Master clear at full power: restart 0000h, flags unchanged
// R10 - Stack full with error reset enabled: restart, set stack-full flag
// R11 - Underflow always sets its flag; restarts only when error reset enabled
// R12 - Watchdog timeout while running: restart 0000h, clear timeout flag
// R13 - Watchdog timeout in idle/sleep: no reset, PC+2, clear timeout, power-down
// R14 - Interrupt wake from low power: PC+2, clear only power-down flag
// R15 - Interrupt wake with its own priority's global enable set loads vector 0008h (high) or 0018h (low)
// R16 - Every reset clears top-of-stack, PC latch, table pointer; wake keeps them (a vectored interrupt wake loads top-of-stack with PC+2)
// R17 - Power-on flag cleared only by power-on; only firmware sets it again
// R18 - Every reset-cause flag is writable by firmware
package reset_cause_pkg;
  // Register byte offsets
  localparam logic [7:0] cause_offset   = 8'h00;
  localparam logic [7:0] control_offset = 8'h04;
  localparam logic [7:0] irq_stat_offset = 8'h08;
  localparam logic [7:0] irq_mask_offset = 8'h0c;
  localparam logic [7:0] restart_offset = 8'h10;
  localparam logic [7:0] tos_offset     = 8'h14;
  localparam logic [7:0] pclat_offset   = 8'h18;
  localparam logic [7:0] tblptr_offset  = 8'h1c;
  // Cause register bit positions
  localparam int bor_bit = 0;
  localparam int por_bit = 1;
  localparam int pd_bit  = 2;
  localparam int to_bit  = 3;
  localparam int ri_bit  = 4;
  localparam int cm_bit  = 5;
  localparam int unf_bit = 6;
  localparam int ful_bit = 7;
  localparam logic [7:0] cause_reset = 8'h3c;
  // Control register bit positions
  localparam int ser_bit  = 0;
  localparam int global_int_enable_high_bit = 1;
  localparam int global_int_enable_low_bit = 2;
  localparam logic [2:0] control_reset = 3'h0;
  // Event indices for the interrupt status
  localparam int ev_por   = 0;
  localparam int ev_bor   = 1;
  localparam int ev_external_master_clear  = 2;
  localparam int ev_cm    = 3;
  localparam int ev_wdtr  = 4;
  localparam int ev_wdtw  = 5;
  localparam int ev_ful   = 6;
  localparam int ev_unf   = 7;
  localparam int ev_ri    = 8;
  localparam int ev_intw  = 9;
  localparam int ev_count = 10;
  // Addresses and vectors
  localparam int pc_width = 21;
  localparam logic [20:0] reset_vector = 21'h000000;
  localparam logic [20:0] high_vector  = 21'h000008;
  localparam logic [20:0] low_vector   = 21'h000018;
  localparam logic [20:0] pc_step      = 21'h000002;
  // Power modes
  typedef enum logic [1:0] {
    mode_full  = 2'h0,
    mode_run   = 2'h1,
    mode_sleep = 2'h2
  } power_mode_type;
  // AXI responses
  localparam logic [1:0] resp_okay   = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
endpackage : reset_cause_pkg

// ==== reset_cause_status_logic.sv ====
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module reset_cause_status_logic (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Reset sources, one-cycle pulses from core logic
  input  wire logic        por_event,
  input  wire logic        brownout_event,
  input  wire logic        config_mismatch_event,
  input  wire logic        watchdog_event,
  input  wire logic        reset_instr_event,
  input  wire logic        stack_full_event,
  input  wire logic        stack_underflow_event,
  input  wire logic        wake_int_event,
  input  wire logic        wake_int_high,
  // Master clear pin, active low, asynchronous
  input  wire logic        external_master_clear_n,
  // Core state
  input  wire logic [1:0]  power_mode,
  input  wire logic [20:0] saved_pc,
  // Restart to the core
  output logic             core_restart,
  output logic             pc_load,
  output logic [20:0]      restart_pc,
  // Interrupt
  output logic             irq
);

  // Address decode used by both read and write paths
  function automatic logic [3:0] reg_index(input logic [7:0] a);
    logic [3:0] r;
    r = 4'h8;
    case (a)
      reset_cause_pkg::cause_offset:    r = 4'h0;
      reset_cause_pkg::control_offset:  r = 4'h1;
      reset_cause_pkg::irq_stat_offset: r = 4'h2;
      reset_cause_pkg::irq_mask_offset: r = 4'h3;
      reset_cause_pkg::restart_offset:  r = 4'h4;
      reset_cause_pkg::tos_offset:      r = 4'h5;
      reset_cause_pkg::pclat_offset:    r = 4'h6;
      reset_cause_pkg::tblptr_offset:   r = 4'h7;
      default:                          r = 4'h8;
    endcase
    return r;
  endfunction : reg_index

  // Master clear synchroniser and edge
  logic [2:0] external_master_clear_sync;
  logic       external_master_clear_fall;

  // Pin crosses two flops before the edge detector sees it
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      external_master_clear_sync <= 3'h7;
    end else begin
      external_master_clear_sync <= {external_master_clear_sync[1:0], external_master_clear_n};
    end
  end

  assign external_master_clear_fall = external_master_clear_sync[2] & ~external_master_clear_sync[1];

  // Write channel state
  logic        aw_held;
  logic        w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        next_aw_held;
  logic        next_w_held;
  logic [7:0]  next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0]  next_w_strb;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        wr_fire;
  logic [3:0]  wr_idx;

  // Address and data are taken in either order
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  assign wr_fire = aw_held & w_held & ~s_axi_bvalid;
  assign wr_idx  = reg_index(aw_addr);

  // Write channel next state
  always_comb begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = (wr_idx == 4'h8) ? reset_cause_pkg::resp_slverr
                                      : reset_cause_pkg::resp_okay;
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  // Write channel registers
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 8'h00;
      w_data       <= 32'h00000000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else begin
      aw_held      <= next_aw_held;
      w_held       <= next_w_held;
      aw_addr      <= next_aw_addr;
      w_data       <= next_w_data;
      w_strb       <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp  <= next_bresp;
    end
  end

  // Block state
  logic [7:0]  cause;
  logic [2:0]  control;
  logic [9:0]  irq_stat;
  logic [9:0]  irq_mask;
  logic [20:0] top_of_stack;
  logic [20:0] pc_latch;
  logic [21:0] table_pointer;
  logic [7:0]  next_cause;
  logic [2:0]  next_control;
  logic [9:0]  next_irq_stat;
  logic [9:0]  next_irq_mask;
  logic [20:0] next_top_of_stack;
  logic [20:0] next_pc_latch;
  logic [21:0] next_table_pointer;
  logic        next_core_restart;
  logic        next_pc_load;
  logic [20:0] next_restart_pc;
  logic [9:0]  events;
  logic        low_power;
  logic        ser_en;
  logic        wr_ok;

  assign low_power = power_mode == reset_cause_pkg::mode_sleep;
  assign ser_en    = control[reset_cause_pkg::ser_bit];
  assign wr_ok     = wr_fire & w_strb[0];

  // Which source acts this cycle; power-on outranks all others
  always_comb begin
    events = 10'h000;
    if (por_event) begin
      events[reset_cause_pkg::ev_por] = 1'b1;
    end else if (brownout_event) begin
      events[reset_cause_pkg::ev_bor] = 1'b1;
    end else if (external_master_clear_fall) begin
      events[reset_cause_pkg::ev_external_master_clear] = 1'b1;
    end else if (config_mismatch_event) begin
      events[reset_cause_pkg::ev_cm] = 1'b1;
    end else if (watchdog_event && !low_power) begin
      events[reset_cause_pkg::ev_wdtr] = 1'b1;
    end else if (watchdog_event) begin
      events[reset_cause_pkg::ev_wdtw] = 1'b1;
    end else if (stack_full_event && ser_en) begin
      events[reset_cause_pkg::ev_ful] = 1'b1;
    end else if (stack_underflow_event) begin
      events[reset_cause_pkg::ev_unf] = 1'b1;
    end else if (reset_instr_event) begin
      events[reset_cause_pkg::ev_ri] = 1'b1;
    end else if (wake_int_event && low_power) begin
      events[reset_cause_pkg::ev_intw] = 1'b1;
    end
  end

  // Flags, restart control and the forced register subset
  always_comb begin
    next_cause         = cause;
    next_control       = control;
    next_irq_stat      = irq_stat;
    next_irq_mask      = irq_mask;
    next_top_of_stack  = top_of_stack;
    next_pc_latch      = pc_latch;
    next_table_pointer = table_pointer;
    next_core_restart  = 1'b0;
    next_pc_load       = 1'b0;
    next_restart_pc    = restart_pc;
    // Firmware writes land first so a hardware event wins below
    if (wr_ok) begin
      case (wr_idx)
        4'h0: next_cause = w_data[7:0]; // R18 R17
        4'h1: next_control = w_data[2:0];
        4'h2: next_irq_stat = irq_stat & ~w_data[9:0];
        4'h3: next_irq_mask = w_data[9:0];
        4'h5: next_top_of_stack = w_data[20:0];
        4'h6: next_pc_latch = w_data[20:0];
        4'h7: next_table_pointer = w_data[21:0];
        default: next_cause = next_cause;
      endcase
    end
    next_irq_stat = next_irq_stat | events;
    if (events[reset_cause_pkg::ev_por]) begin
      next_cause = reset_cause_pkg::cause_reset; // R3 R17
    end
    if (events[reset_cause_pkg::ev_bor]) begin
      next_cause[reset_cause_pkg::cm_bit]  = 1'b1; // R5
      next_cause[reset_cause_pkg::ri_bit]  = 1'b1;
      next_cause[reset_cause_pkg::to_bit]  = 1'b1;
      next_cause[reset_cause_pkg::pd_bit]  = 1'b1;
      next_cause[reset_cause_pkg::bor_bit] = 1'b0;
    end
    if (events[reset_cause_pkg::ev_external_master_clear]) begin
      // Full power leaves every flag alone
      if (power_mode == reset_cause_pkg::mode_run) begin
        next_cause[reset_cause_pkg::to_bit] = 1'b1; // R7
      end else if (low_power) begin
        next_cause[reset_cause_pkg::to_bit] = 1'b1; // R8
        next_cause[reset_cause_pkg::pd_bit] = 1'b0; // R8
      end
    end
    if (events[reset_cause_pkg::ev_cm]) begin
      next_cause[reset_cause_pkg::cm_bit] = 1'b0; // R6
    end
    if (events[reset_cause_pkg::ev_wdtr]) begin
      next_cause[reset_cause_pkg::to_bit] = 1'b0; // R12
    end
    if (events[reset_cause_pkg::ev_wdtw]) begin
      next_cause[reset_cause_pkg::to_bit] = 1'b0; // R13
      next_cause[reset_cause_pkg::pd_bit] = 1'b0; // R13
    end
    if (events[reset_cause_pkg::ev_ful]) begin
      next_cause[reset_cause_pkg::ful_bit] = 1'b1; // R10
    end
    if (events[reset_cause_pkg::ev_unf]) begin
      next_cause[reset_cause_pkg::unf_bit] = 1'b1; // R11
    end
    if (events[reset_cause_pkg::ev_ri]) begin
      next_cause[reset_cause_pkg::ri_bit] = 1'b0; // R4
    end
    if (events[reset_cause_pkg::ev_intw]) begin
      next_cause[reset_cause_pkg::pd_bit] = 1'b0; // R14
    end
    // Hard resets restart at the reset vector and clear the subset
    if (|events[reset_cause_pkg::ev_ri:reset_cause_pkg::ev_por] &&
        !events[reset_cause_pkg::ev_wdtw] &&
        !(events[reset_cause_pkg::ev_unf] && !ser_en)) begin
      next_core_restart  = 1'b1; // R1 R9 R11
      next_pc_load       = 1'b1;
      next_restart_pc    = reset_cause_pkg::reset_vector;
      next_top_of_stack  = 21'h000000; // R16
      next_pc_latch      = 21'h000000; // R16
      next_table_pointer = 22'h000000; // R16
    end
    // Wake-ups resume at PC+2; a vectored interrupt wake resumes at its vector and loads top-of-stack with PC+2
    if (events[reset_cause_pkg::ev_wdtw]) begin
      next_pc_load    = 1'b1; // R2 R13
      next_restart_pc = 21'(saved_pc + reset_cause_pkg::pc_step);
    end
    if (events[reset_cause_pkg::ev_intw]) begin
      next_pc_load    = 1'b1;
      next_restart_pc = 21'(saved_pc + reset_cause_pkg::pc_step); // R14
      if (wake_int_high && control[reset_cause_pkg::global_int_enable_high_bit]) begin
        next_restart_pc   = reset_cause_pkg::high_vector; // R15
        next_top_of_stack = 21'(saved_pc + reset_cause_pkg::pc_step);
      end else if (!wake_int_high &&
                   control[reset_cause_pkg::global_int_enable_low_bit]) begin
        next_restart_pc   = reset_cause_pkg::low_vector; // R15
        next_top_of_stack = 21'(saved_pc + reset_cause_pkg::pc_step);
      end
    end
  end

  // Block state registers; async reset is the power-on state
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cause         <= reset_cause_pkg::cause_reset;
      control       <= reset_cause_pkg::control_reset;
      irq_stat      <= 10'h000;
      irq_mask      <= 10'h000;
      top_of_stack  <= 21'h000000;
      pc_latch      <= 21'h000000;
      table_pointer <= 22'h000000;
      core_restart  <= 1'b0;
      pc_load       <= 1'b0;
      restart_pc    <= 21'h000000;
    end else begin
      cause         <= next_cause;
      control       <= next_control;
      irq_stat      <= next_irq_stat;
      irq_mask      <= next_irq_mask;
      top_of_stack  <= next_top_of_stack;
      pc_latch      <= next_pc_latch;
      table_pointer <= next_table_pointer;
      core_restart  <= next_core_restart;
      pc_load       <= next_pc_load;
      restart_pc    <= next_restart_pc;
    end
  end

  // Level interrupt from any unmasked sticky event
  assign irq = |(irq_stat & irq_mask);

  // Read channel
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic        next_rvalid;
  logic [31:0] rd_value;
  logic [3:0]  rd_idx;

  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_idx = reg_index(s_axi_araddr);

  // Read mux; unused upper bits read as zero
  always_comb begin
    rd_value = 32'h00000000;
    case (rd_idx)
      4'h0: rd_value = {24'h000000, cause};
      4'h1: rd_value = {29'h00000000, control};
      4'h2: rd_value = {22'h000000, irq_stat};
      4'h3: rd_value = {22'h000000, irq_mask};
      4'h4: rd_value = {11'h000, restart_pc};
      4'h5: rd_value = {11'h000, top_of_stack};
      4'h6: rd_value = {11'h000, pc_latch};
      4'h7: rd_value = {10'h000, table_pointer};
      default: rd_value = 32'h00000000;
    endcase
  end

  // One read in flight; data held until rready
  always_comb begin
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    next_rvalid = s_axi_rvalid;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata  = rd_value;
      next_rresp  = (rd_idx == 4'h8) ? reset_cause_pkg::resp_slverr
                                     : reset_cause_pkg::resp_okay;
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // Read channel registers
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'h0;
      s_axi_rvalid <= 1'b0;
    end else begin
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
      s_axi_rvalid <= next_rvalid;
    end
  end

endmodule : reset_cause_status_logic
`default_nettype wire

// ==== reset_cause_chk.sv ====
`timescale 1ns/1ns
`default_nettype none
module reset_cause_chk (
  // Clock, reset and bus handshakes
  input wire logic        ref_clk,
  input wire logic        resetn,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  // Events and core state
  input wire logic        por_event,
  input wire logic        brownout_event,
  input wire logic        config_mismatch_event,
  input wire logic        watchdog_event,
  input wire logic        reset_instr_event,
  input wire logic        stack_full_event,
  input wire logic        stack_underflow_event,
  input wire logic        wake_int_event,
  input wire logic        external_master_clear_n,
  input wire logic [1:0]  power_mode,
  input wire logic [20:0] saved_pc,
  // Restart outputs
  input wire logic        core_restart,
  input wire logic        pc_load,
  input wire logic [20:0] restart_pc
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic [3:0] pin_hist;
  logic [3:0] next_pin_hist;
  // Pin history: a falling pin may still sit in the synchroniser
  always_comb begin
    next_pin_hist = {pin_hist[2:0], external_master_clear_n};
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pin_hist <= 4'hf;
    end else begin
      pin_hist <= next_pin_hist;
    end
  end
  // Event classes; stack events excluded where priority is unclear
  wire quiet = (&pin_hist) && external_master_clear_n;
  wire top3 = por_event || brownout_event || config_mismatch_event;
  wire stk = stack_full_event || stack_underflow_event;
  wire hard = top3 || reset_instr_event ||
              (watchdog_event && power_mode != 2'h2);
  wire any_ev = hard || stk || watchdog_event || wake_int_event;
  sequence pin_fall;
    external_master_clear_n ##1 !external_master_clear_n [*2];
  endsequence
  a_hard_restart: assert property (hard && !stk && quiet |=>
    core_restart && pc_load && restart_pc == 21'h0)
    else $error("hard reset did not restart at zero");
  a_wdt_wake: assert property (watchdog_event && power_mode == 2'h2 &&
    !top3 && quiet |=> pc_load && !core_restart &&
    restart_pc == $past(saved_pc) + 21'h2)
    else $error("watchdog wake address wrong");
  a_int_wake: assert property (wake_int_event && power_mode == 2'h2 &&
    !hard && !stk && !watchdog_event && quiet |=> pc_load && !core_restart
    && (restart_pc == 21'h8 || restart_pc == 21'h18 ||
    restart_pc == $past(saved_pc) + 21'h2))
    else $error("interrupt wake address wrong");
  a_restart_load: assert property (core_restart |-> pc_load)
    else $error("restart without address load");
  a_no_spurious: assert property (!any_ev && quiet |=> !pc_load)
    else $error("address load without cause");
  a_pc_hold: assert property (!pc_load |-> $stable(restart_pc))
    else $error("restart address moved");
  a_external_master_clear_restart: assert property (pin_fall |-> ##[0:4] core_restart)
    else $error("master clear gave no restart");
  a_b_done: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid)
    else $error("write response not retired");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
endmodule : reset_cause_chk
bind reset_cause_status_logic reset_cause_chk chk (
  .ref_clk, .resetn, .s_axi_bvalid, .s_axi_bready, .s_axi_arready,
  .s_axi_rvalid, .por_event, .brownout_event, .config_mismatch_event,
  .watchdog_event, .reset_instr_event, .stack_full_event,
  .stack_underflow_event, .wake_int_event, .external_master_clear_n,
  .power_mode, .saved_pc, .core_restart, .pc_load, .restart_pc
);
`default_nettype wire

// ==== reset_cause_status_logic_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module reset_cause_status_logic_tb;
  typedef struct packed {
    logic [3:0] e;
    logic [1:0] m;
    logic [2:0] c;
    logic [7:0] s;
    logic [7:0] r;
    logic [2:0] k;
  } case_type;
  logic        ref_clk, resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, wake_int_high, irq;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, core_restart, pc_load, external_master_clear_n;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, ev;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, power_mode, wr_resp;
  logic [20:0] saved_pc, restart_pc;
  int          miscompares, total_checks, cycles;
  // Event pulses from one vector
  wire por_event = ev[0];
  wire brownout_event = ev[1];
  wire config_mismatch_event = ev[2];
  wire watchdog_event = ev[3];
  wire reset_instr_event = ev[4];
  wire stack_full_event = ev[5];
  wire stack_underflow_event = ev[6];
  wire wake_int_event = ev[7];
  // Event, mode, control, set, clear, kind (e 8 is the pin)
  case_type tbl [17] = '{
    '{4'h0, 2'h0, 3'h0, 8'h3c, 8'hc3, 3'h1},
    '{4'h1, 2'h0, 3'h0, 8'h3c, 8'h01, 3'h1},
    '{4'h2, 2'h0, 3'h0, 8'h00, 8'h20, 3'h1},
    '{4'h3, 2'h0, 3'h0, 8'h00, 8'h08, 3'h1},
    '{4'h3, 2'h1, 3'h0, 8'h00, 8'h08, 3'h1},
    '{4'h3, 2'h2, 3'h0, 8'h00, 8'h0c, 3'h2},
    '{4'h4, 2'h0, 3'h0, 8'h00, 8'h10, 3'h1},
    '{4'h5, 2'h0, 3'h1, 8'h80, 8'h00, 3'h1},
    '{4'h5, 2'h0, 3'h0, 8'h00, 8'h00, 3'h0},
    '{4'h6, 2'h0, 3'h1, 8'h40, 8'h00, 3'h1},
    '{4'h6, 2'h0, 3'h0, 8'h40, 8'h00, 3'h0},
    '{4'h7, 2'h2, 3'h0, 8'h00, 8'h04, 3'h2},
    '{4'h7, 2'h2, 3'h2, 8'h00, 8'h04, 3'h3},
    '{4'h7, 2'h2, 3'h4, 8'h00, 8'h04, 3'h4},
    '{4'h8, 2'h1, 3'h0, 8'h08, 8'h00, 3'h1},
    '{4'h8, 2'h2, 3'h0, 8'h08, 8'h04, 3'h1},
    '{4'h8, 2'h0, 3'h0, 8'h00, 8'h00, 3'h1}
  };
  reset_cause_status_logic DUT (.*);
  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string what);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, seen, exp);
    end
  endtask : chk
  // Address and data offered together, each released when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] resp);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (aw && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        aw = 1'b0;
      end
      if (w && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        w = 1'b0;
      end
    end while (aw || w);
    do @(posedge ref_clk); while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] resp);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge ref_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                        input string what);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    chk(d, exp, what);
  endtask : rd_chk
  task automatic test_reset;
    logic [31:0] d;
    logic [1:0]  r;
    rd_chk(reset_cause_pkg::cause_offset, 32'h3c, "cause");
    rd_chk(reset_cause_pkg::tos_offset, 32'h0, "stack top");
    axi_rd(8'h20, d, r);
    chk(d, 32'h0, "unmapped data");
    chk({30'h0, r}, {30'h0, reset_cause_pkg::resp_slverr}, "resp");
    axi_wr(reset_cause_pkg::cause_offset, 32'hff, wr_resp);
    chk({30'h0, wr_resp}, {30'h0, reset_cause_pkg::resp_okay}, "bresp");
    rd_chk(reset_cause_pkg::cause_offset, 32'hff, "firmware");
    $display("test_reset done");
  endtask : test_reset
  // One event from a known flag state; no overlap with the pin
  task automatic run_case(input case_type t, input logic [7:0] base);
    logic ld;
    logic rs;
    logic [20:0] pc;
    logic [20:0] xp;
    logic [20:0] nx;
    ld = 1'b0;
    rs = 1'b0;
    pc = 21'h0;
    nx = saved_pc + reset_cause_pkg::pc_step;
    axi_wr(reset_cause_pkg::control_offset, {29'h0, t.c}, wr_resp);
    axi_wr(reset_cause_pkg::cause_offset, {24'h0, base}, wr_resp);
    axi_wr(reset_cause_pkg::tos_offset, 32'h1234, wr_resp);
    axi_wr(reset_cause_pkg::pclat_offset, 32'h55, wr_resp);
    @(posedge ref_clk);
    power_mode <= t.m;
    wake_int_high <= t.c[1];
    @(posedge ref_clk);
    if (t.e == 4'h8) external_master_clear_n <= 1'b0;
    else ev[t.e[2:0]] <= 1'b1;
    @(posedge ref_clk);
    ev <= 8'h00;
    for (int i = 0; i < 10; i++) begin
      @(negedge ref_clk);
      if (pc_load === 1'b1) begin
        ld = 1'b1;
        rs = core_restart;
        pc = restart_pc;
      end
    end
    @(posedge ref_clk);
    external_master_clear_n <= 1'b1;
    case (t.k)
      3'h1: xp = reset_cause_pkg::reset_vector;
      3'h2: xp = nx;
      3'h3: xp = reset_cause_pkg::high_vector;
      default: xp = reset_cause_pkg::low_vector;
    endcase
    chk({31'h0, ld}, {31'h0, t.k != 3'h0}, "load");
    chk({31'h0, rs}, {31'h0, t.k == 3'h1}, "hard");
    if (t.k != 3'h0) chk({11'h0, pc}, {11'h0, xp}, "address");
    rd_chk(reset_cause_pkg::cause_offset, {24'h0, (base | t.s) & ~t.r},
           "flags");
    xp = (t.k == 3'h1) ? 21'h0 : (t.k > 3'h2) ? nx : 21'h1234;
    rd_chk(reset_cause_pkg::tos_offset, {11'h0, xp}, "stack top");
    rd_chk(reset_cause_pkg::pclat_offset, (t.k == 3'h1) ? 32'h0 : 32'h55,
           "latch");
  endtask : run_case
  task automatic test_events;
    foreach (tbl[i]) begin
      run_case(tbl[i], 8'h00);
      run_case(tbl[i], 8'hff);
    end
    $display("test_events done");
  endtask : test_events
  task automatic test_irq;
    axi_wr(reset_cause_pkg::irq_mask_offset, 32'h3ff, wr_resp);
    axi_wr(reset_cause_pkg::irq_stat_offset, 32'h3ff, wr_resp);
    @(negedge ref_clk);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    run_case(tbl[6], 8'hff);
    chk({31'h0, irq}, 32'h1, "irq raised");
    rd_chk(reset_cause_pkg::irq_stat_offset, 32'h100, "irq status");
    axi_wr(reset_cause_pkg::irq_mask_offset, 32'h0, wr_resp);
    @(negedge ref_clk);
    chk({31'h0, irq}, 32'h0, "irq masked");
    axi_wr(reset_cause_pkg::irq_mask_offset, 32'h3ff, wr_resp);
    axi_wr(reset_cause_pkg::irq_stat_offset, 32'h100, wr_resp);
    @(negedge ref_clk);
    chk({31'h0, irq}, 32'h0, "irq after clear");
    $display("test_irq done");
  endtask : test_irq
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict
  // Watchdog on the run; a full run takes under two thousand cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      print_verdict;
    end
  end
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, wake_int_high} = 3'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    ev = 8'h00;
    power_mode = 2'h0;
    saved_pc = 21'h01234a;
    external_master_clear_n = 1'b1;
    resetn = 1'b0;
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    test_reset;
    test_events;
    test_irq;
    print_verdict;
  end
endmodule : reset_cause_status_logic_tb
`default_nettype wire
